// ===== pkg/aac_params.svh
// Offsets, field positions, reset values and timing counts of the advertisement block
`ifndef AAC_PARAMS_SVH
`define AAC_PARAMS_SVH

`define AAC_ADDR_BASIC_CTRL  5'h00
`define AAC_ADDR_ADVERT      5'h04

`define AAC_BC_SOFT_RESET    15
`define AAC_BC_SPEED_100     13
`define AAC_BC_AN_ENABLE     12
`define AAC_BC_AN_RESTART    9
`define AAC_BC_FULL_DUPLEX   8
`define AAC_BC_RESET_VAL     16'h3100
`define AAC_BC_STORE_MASK    16'h3D80

`define AAC_ADV_ABIL_HI      8
`define AAC_ADV_ABIL_LO      5
`define AAC_ADV_RESET_VAL    16'h01E1

`define AAC_CLK_NS           20
`define AAC_FLP_SLOT_NS      62500
`define AAC_FLP_SLOT_CYC     (`AAC_FLP_SLOT_NS / `AAC_CLK_NS)
`define AAC_FLP_WIDTH_NS     100
`define AAC_FLP_WIDTH_CYC    (`AAC_FLP_WIDTH_NS / `AAC_CLK_NS)
`define AAC_FLP_LAST_SLOT    32
`define AAC_FLP_BURST_US     16000
`define AAC_FLP_BURST_CYC    (`AAC_FLP_BURST_US * 1000 / `AAC_CLK_NS)
`define AAC_BREAK_MS         1500
`define AAC_BREAK_CYC        (`AAC_BREAK_MS * 1000000 / `AAC_CLK_NS)
`define AAC_MDIX_SLOT_US     60000
`define AAC_MDIX_SLOT_CYC    (`AAC_MDIX_SLOT_US * 1000 / `AAC_CLK_NS)
`define AAC_LFSR_SEED        8'hA5

`endif

// ===== pkg/aac_pkg.sv
// Types shared by the advertisement block
package aac_pkg;

	typedef enum logic [3:0] {
		ST_OFF   = 4'b0001,
		ST_BREAK = 4'b0010,
		ST_NEG   = 4'b0100,
		ST_LINK  = 4'b1000
	} aac_state_t;

	// Packed in the same order as the ability field, top bit first
	typedef struct packed {
		logic fd100;
		logic hd100;
		logic fd10;
		logic hd10;
	} aac_ability_t;

	typedef struct packed {
		logic valid;
		logic speed_100;
		logic full_duplex;
	} aac_res_t;

endpackage

// ===== design/aac_flp_tx.sv
// Fast link pulse burst serializer for the advertised code word
`timescale 1ns/100ps
`include "aac_params.svh"

module aac_flp_tx #(
	parameter int unsigned BURST_CYC = `AAC_FLP_BURST_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        send_en,
	input  wire logic [15:0] code_word,
	output logic             flp_pulse_q
);

	localparam int unsigned SLOT_CYC  = `AAC_FLP_SLOT_CYC;
	localparam int unsigned WIDTH_CYC = `AAC_FLP_WIDTH_CYC;

	logic [31:0] tot_q, tot_d;
	logic [31:0] cyc_q, cyc_d;
	logic [5:0]  slot_q, slot_d;
	logic        pulse_d;

	// Even slots carry clock pulses, odd slots carry code bits, bit 0 first
	always_comb begin
		tot_d   = tot_q + 32'h0000_0001;
		cyc_d   = cyc_q + 32'h0000_0001;
		slot_d  = slot_q;
		pulse_d = 1'b0;
		if (!send_en) begin
			tot_d  = 32'h0000_0000;
			cyc_d  = 32'h0000_0000;
			slot_d = 6'h00;
		end else if (tot_q == 32'(BURST_CYC - 1)) begin
			tot_d  = 32'h0000_0000;
			cyc_d  = 32'h0000_0000;
			slot_d = 6'h00;
		end else if (cyc_q == 32'(SLOT_CYC - 1)) begin
			cyc_d = 32'h0000_0000;
			if (slot_q != 6'h3F) begin
				slot_d = slot_q + 6'h01;
			end
		end
		if (send_en && cyc_q < 32'(WIDTH_CYC) && slot_q <= 6'(`AAC_FLP_LAST_SLOT)) begin
			pulse_d = !slot_q[0] || code_word[slot_q[4:1]];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tot_q       <= 32'h0000_0000;
			cyc_q       <= 32'h0000_0000;
			slot_q      <= 6'h00;
			flp_pulse_q <= 1'b0;
		end else begin
			tot_q       <= tot_d;
			cyc_q       <= cyc_d;
			slot_q      <= slot_d;
			flp_pulse_q <= pulse_d;
		end
	end

	AST_FLP_WIDTH: assert property (@(posedge sys_clk) disable iff (!rst_b || !send_en)
		$rose(flp_pulse_q) |-> flp_pulse_q [*5] ##1 !flp_pulse_q)
		else $error("Link pulse width is not five cycles");

	AST_FLP_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!send_en |=> !flp_pulse_q)
		else $error("Link pulse sent while negotiation is not running");

endmodule

// ===== design/aac_autoneg.sv
// Strap capture, management registers, mode resolution and crossover control
`timescale 1ns/100ps
`include "aac_params.svh"

// Behaviour
// - At reset release, strap levels load into the four ability bits of advertisement.
// - Two straps: 00 10M both, 01 100M both, 10 half only, 11 all.
// - One strap: low gives half duplex only, high gives all four modes.
// - Management writes to basic control change negotiation behaviour at any time.
// - Four modes supported; negotiation picks the best mode common to both ends.
// - Both ends send their advertised abilities as link pulse bursts while negotiating.
// - With automatic crossover active, transmit and receive pair roles may swap.
// - Line signalling follows the resolved speed, 10 or 100 Mb/s.
// - Priority: 100 full, 100 half, 10 full, 10 half.
// - Forced speed and duplex bits act only while negotiation is disabled.
// - Crossover is on by default, off when its strap is low at reset.
module aac_autoneg #(
	parameter bit          TWO_STRAPS    = 1'b1,
	parameter int unsigned BURST_CYC     = `AAC_FLP_BURST_CYC,
	parameter int unsigned BREAK_CYC     = `AAC_BREAK_CYC,
	parameter int unsigned MDIX_SLOT_CYC = `AAC_MDIX_SLOT_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        advert_strap_lo,
	input  wire logic        advert_strap_hi,
	input  wire logic        crossover_strap_enable,
	input  wire logic [4:0]  mgmt_addr,
	input  wire logic [15:0] mgmt_wdata,
	input  wire logic        mgmt_wr,
	input  wire logic        mgmt_rd,
	output logic      [15:0] mgmt_rdata_q,
	input  wire logic [15:0] partner_word,
	input  wire logic        partner_word_valid,
	input  wire logic        link_good,
	output logic             flp_pulse_q,
	output logic             mdix_swap_q,
	output logic             speed_100_q,
	output logic             full_duplex_q,
	output logic             mode_valid_q
);

	function automatic aac_pkg::aac_ability_t aac_strap_ability(
		input logic two, input logic hi, input logic lo);
		aac_pkg::aac_ability_t a;
		if (two) begin
			unique case ({hi, lo})
				2'b00:   a = 4'b0011;
				2'b01:   a = 4'b1100;
				2'b10:   a = 4'b0101;
				default: a = 4'b1111;
			endcase
		end else begin
			a = lo ? 4'b1111 : 4'b0101;
		end
		return a;
	endfunction

	function automatic aac_pkg::aac_res_t aac_resolve(input aac_pkg::aac_ability_t c);
		aac_pkg::aac_res_t r;
		r = '0;
		if (c.fd100) begin
			r = 3'b111;
		end else if (c.hd100) begin
			r = 3'b110;
		end else if (c.fd10) begin
			r = 3'b101;
		end else if (c.hd10) begin
			r = 3'b100;
		end
		return r;
	endfunction

	logic [15:0]           bc_q, bc_d;
	logic [15:0]           adv_q, adv_d;
	logic                  cap_q, cap_d;
	logic                  crossover_strap_enable_q, crossover_strap_enable_d;
	logic                  wr_basic, wr_advert, restart_req;
	aac_pkg::aac_ability_t common;
	aac_pkg::aac_res_t     res;
	aac_pkg::aac_state_t   state_q, state_d;
	logic [31:0]           brk_q, brk_d;
	logic [31:0]           mx_cnt_q, mx_cnt_d;
	logic [7:0]            lfsr_q, lfsr_d;
	logic                  swap_d, speed_d, full_d, valid_d;
	logic [15:0]           rdata_d;

	assign wr_basic    = mgmt_wr && mgmt_addr == `AAC_ADDR_BASIC_CTRL;
	assign wr_advert   = mgmt_wr && mgmt_addr == `AAC_ADDR_ADVERT;
	assign restart_req = wr_basic && (mgmt_wdata[`AAC_BC_AN_RESTART]
		|| mgmt_wdata[`AAC_BC_SOFT_RESET]
		|| (mgmt_wdata[`AAC_BC_AN_ENABLE] && !bc_q[`AAC_BC_AN_ENABLE]));
	assign common      = adv_q[`AAC_ADV_ABIL_HI:`AAC_ADV_ABIL_LO]
		& partner_word[`AAC_ADV_ABIL_HI:`AAC_ADV_ABIL_LO];
	assign res         = aac_resolve(common);

	// Registers; the restart and soft reset bits clear themselves
	always_comb begin
		bc_d      = bc_q;
		adv_d     = adv_q;
		cap_d     = 1'b1;
		crossover_strap_enable_d = crossover_strap_enable_q;
		rdata_d   = mgmt_rdata_q;
		if (!cap_q) begin
			// Taken on the first edge after release, never again
			adv_d[`AAC_ADV_ABIL_HI:`AAC_ADV_ABIL_LO] =
				aac_strap_ability(TWO_STRAPS, advert_strap_hi, advert_strap_lo);
			crossover_strap_enable_d = crossover_strap_enable;
		end
		if (wr_basic) begin
			bc_d = mgmt_wdata[`AAC_BC_SOFT_RESET] ? `AAC_BC_RESET_VAL
				: (mgmt_wdata & `AAC_BC_STORE_MASK);
		end
		if (wr_advert) begin
			adv_d[`AAC_ADV_ABIL_HI:`AAC_ADV_ABIL_LO] =
				mgmt_wdata[`AAC_ADV_ABIL_HI:`AAC_ADV_ABIL_LO];
		end
		if (mgmt_rd) begin
			unique case (mgmt_addr)
				`AAC_ADDR_BASIC_CTRL: rdata_d = bc_q;
				`AAC_ADDR_ADVERT:     rdata_d = adv_q;
				default:              rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			bc_q         <= `AAC_BC_RESET_VAL;
			adv_q        <= `AAC_ADV_RESET_VAL;
			cap_q        <= 1'b0;
			crossover_strap_enable_q    <= 1'b1;
			mgmt_rdata_q <= 16'h0000;
		end else begin
			bc_q         <= bc_d;
			adv_q        <= adv_d;
			cap_q        <= cap_d;
			crossover_strap_enable_q    <= crossover_strap_enable_d;
			mgmt_rdata_q <= rdata_d;
		end
	end

	// Negotiation sequence; a restart silences the line for the break time
	always_comb begin
		state_d = state_q;
		if (!bc_d[`AAC_BC_AN_ENABLE]) begin
			state_d = aac_pkg::ST_OFF;
		end else if (restart_req) begin
			state_d = aac_pkg::ST_BREAK;
		end else begin
			unique case (state_q)
				aac_pkg::ST_OFF:   state_d = aac_pkg::ST_BREAK;
				aac_pkg::ST_BREAK: begin
					if (brk_q == 32'(BREAK_CYC - 1)) begin
						state_d = aac_pkg::ST_NEG;
					end
				end
				aac_pkg::ST_NEG: begin
					if (partner_word_valid && res.valid) begin
						state_d = aac_pkg::ST_LINK;
					end
				end
				aac_pkg::ST_LINK: begin
					if (!link_good) begin
						state_d = aac_pkg::ST_NEG;
					end
				end
				default: state_d = aac_pkg::ST_NEG;
			endcase
		end
		brk_d = (state_q == aac_pkg::ST_BREAK && state_d == aac_pkg::ST_BREAK)
			? brk_q + 32'h0000_0001 : 32'h0000_0000;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= aac_pkg::ST_NEG;
			brk_q   <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			brk_q   <= brk_d;
		end
	end

	// Mode outputs and crossover hunting
	always_comb begin
		speed_d  = speed_100_q;
		full_d   = full_duplex_q;
		valid_d  = 1'b0;
		swap_d   = mdix_swap_q;
		lfsr_d   = lfsr_q;
		mx_cnt_d = 32'h0000_0000;
		unique case (state_q)
			aac_pkg::ST_OFF: begin
				speed_d = bc_q[`AAC_BC_SPEED_100];
				full_d  = bc_q[`AAC_BC_FULL_DUPLEX];
				valid_d = 1'b1;
				// Crossover hunting relies on negotiation, so forced mode stays straight
				swap_d  = 1'b0;
			end
			aac_pkg::ST_NEG: begin
				if (partner_word_valid && res.valid) begin
					speed_d = res.speed_100;
					full_d  = res.full_duplex;
				end
				if (cap_q && crossover_strap_enable_q) begin
					mx_cnt_d = mx_cnt_q + 32'h0000_0001;
					if (mx_cnt_q == 32'(MDIX_SLOT_CYC - 1)) begin
						mx_cnt_d = 32'h0000_0000;
						lfsr_d   = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
						swap_d   = mdix_swap_q ^ lfsr_q[0];
					end
				end
			end
			aac_pkg::ST_LINK: valid_d = 1'b1;
			default:          valid_d = 1'b0;
		endcase
		if (!cap_q || !crossover_strap_enable_q) begin
			swap_d = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			speed_100_q   <= 1'b1;
			full_duplex_q <= 1'b0;
			mode_valid_q  <= 1'b0;
			mdix_swap_q   <= 1'b0;
			lfsr_q        <= `AAC_LFSR_SEED;
			mx_cnt_q      <= 32'h0000_0000;
		end else begin
			speed_100_q   <= speed_d;
			full_duplex_q <= full_d;
			mode_valid_q  <= valid_d;
			mdix_swap_q   <= swap_d;
			lfsr_q        <= lfsr_d;
			mx_cnt_q      <= mx_cnt_d;
		end
	end

	aac_flp_tx #(
		.BURST_CYC (BURST_CYC)
	) u_flp_tx (
		.sys_clk     (sys_clk),
		.rst_b       (rst_b),
		.send_en     (state_q == aac_pkg::ST_NEG),
		.code_word   (adv_q),
		.flp_pulse_q (flp_pulse_q)
	);

	AST_STRAP_CAPTURE: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(cap_q) && !$past(wr_advert) |-> adv_q[8:5] ==
		$past(aac_strap_ability(TWO_STRAPS, advert_strap_hi, advert_strap_lo)))
		else $error("Advertised abilities do not match the straps");

	AST_STRAP_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cap_q && !wr_advert |=> $stable(adv_q[8:5]))
		else $error("Advertised abilities changed without a management write");

	AST_BASIC_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_basic && mgmt_wdata[12] && mgmt_wdata[9] |=> state_q == aac_pkg::ST_BREAK)
		else $error("Restart write did not start a new negotiation");

	AST_FORCED_MODE: assert property (@(posedge sys_clk) disable iff (!rst_b)
		state_q == aac_pkg::ST_OFF |=> speed_100_q == $past(bc_q[13])
		&& full_duplex_q == $past(bc_q[8]))
		else $error("Forced speed or duplex not applied");

	AST_RESOLVE: assert property (@(posedge sys_clk) disable iff (!rst_b)
		state_q == aac_pkg::ST_NEG && partner_word_valid && res.valid && bc_d[12]
		&& !restart_req |=> state_q == aac_pkg::ST_LINK
		&& {speed_100_q, full_duplex_q} == $past(res[1:0]) ##1 mode_valid_q)
		else $error("Resolved mode is not the best common one");

	AST_CROSS_STRAP: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cap_q && !crossover_strap_enable_q |-> !mdix_swap_q)
		else $error("Pairs swapped with crossover strapped off");

	AST_CROSS_FORCED: assert property (@(posedge sys_clk) disable iff (!rst_b)
		state_q == aac_pkg::ST_OFF |=> !mdix_swap_q)
		else $error("Pairs swapped in forced mode");

	AST_BURST_ONLY_NEG: assert property (@(posedge sys_clk) disable iff (!rst_b)
		state_q != aac_pkg::ST_NEG [*2] |-> !flp_pulse_q)
		else $error("Link pulses outside negotiation");

endmodule

// ===== tb/aac_link_partner.sv
// Cable link partner model answering the device bursts with its ability word
`timescale 1ns/100ps
module aac_link_partner (
	input  wire logic                 sys_clk,
	input  wire logic                 rst_b,
	input  wire logic                 flp_pulse,
	input  wire logic                 en,
	input  wire aac_pkg::aac_ability_t abil,
	output logic               [15:0] partner_word,
	output logic                      partner_word_valid,
	output logic                      link_good
);
	logic seen_q;

	// Idle word toggles every cycle so a stale value is never mistaken for data
	always_ff @(negedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			seen_q             <= 1'b0;
			partner_word       <= 16'h0000;
			partner_word_valid <= 1'b0;
			link_good          <= 1'b0;
		end else begin
			seen_q             <= en && (seen_q || flp_pulse);
			partner_word_valid <= en && seen_q;
			link_good          <= en && seen_q;
			partner_word       <= (en && seen_q) ? {7'h00, abil, 5'h01} : ~partner_word;
		end
	end
endmodule

// ===== tb/aac_autoneg_test.sv
// Self-checking bench for strap capture, registers and negotiation
`timescale 1ns/100ps
`include "aac_params.svh"
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin n_fail++; \
	$display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module aac_autoneg_test;
	logic                  sys_clk = 1'b0;
	logic                  rst_b = 1'b0;
	logic                  advert_strap_lo = 1'b0;
	logic                  advert_strap_hi = 1'b0;
	logic                  crossover_strap_enable = 1'b1;
	logic           [4:0]  mgmt_addr = 5'h00;
	logic           [15:0] mgmt_wdata = 16'h0000;
	logic                  mgmt_wr = 1'b0;
	logic                  mgmt_rd = 1'b0;
	logic           [15:0] mgmt_rdata_q, one_rdata, rdata, rdata1, partner_word;
	logic                  partner_word_valid, link_good, flp_pulse_q, mdix_swap_q;
	logic                  speed_100_q, full_duplex_q, mode_valid_q, p_en = 1'b0, seen;
	aac_pkg::aac_ability_t p_abil = 4'h0;
	int                    n_fail = 0, checked = 0, n_flp = 0, n0;
	logic           [3:0]  stab [4] = '{4'b0011, 4'b1100, 4'b0101, 4'b1111};
	logic           [3:0]  ptab [4] = '{4'b1111, 4'b0110, 4'b0011, 4'b0001};
	// Shortened timers keep the run small; bursts only reach their first slot
	localparam int unsigned tb_burst = 200;
	localparam int unsigned tb_break = 20;
	localparam int unsigned tb_mdix  = 50;

	always #10 sys_clk = ~sys_clk;
	always @(negedge sys_clk) if (flp_pulse_q === 1'b1) n_flp++;

	aac_autoneg #(.TWO_STRAPS(1'b1), .BURST_CYC(tb_burst), .BREAK_CYC(tb_break),
		.MDIX_SLOT_CYC(tb_mdix)) dut_u (
		.sys_clk, .rst_b, .advert_strap_lo, .advert_strap_hi, .crossover_strap_enable,
		.mgmt_addr, .mgmt_wdata, .mgmt_wr, .mgmt_rd, .mgmt_rdata_q, .partner_word,
		.partner_word_valid, .link_good, .flp_pulse_q, .mdix_swap_q, .speed_100_q,
		.full_duplex_q, .mode_valid_q);
	aac_autoneg #(.TWO_STRAPS(1'b0), .BURST_CYC(tb_burst), .BREAK_CYC(tb_break),
		.MDIX_SLOT_CYC(tb_mdix)) dut1_u (
		.sys_clk, .rst_b, .advert_strap_lo, .advert_strap_hi, .crossover_strap_enable,
		.mgmt_addr, .mgmt_wdata, .mgmt_wr, .mgmt_rd, .mgmt_rdata_q(one_rdata), .partner_word,
		.partner_word_valid, .link_good, .flp_pulse_q(), .mdix_swap_q(), .speed_100_q(),
		.full_duplex_q(), .mode_valid_q());
	aac_link_partner link_u (.sys_clk, .rst_b, .flp_pulse(flp_pulse_q), .en(p_en),
		.abil(p_abil), .partner_word, .partner_word_valid, .link_good);

	function automatic logic [15:0] adv(input logic [3:0] a);
		return 16'h0001 | {7'h00, a, 5'h00};
	endfunction

	task automatic rd(input logic [4:0] a);
		@(negedge sys_clk);
		mgmt_addr = a;
		mgmt_rd = 1'b1;
		@(negedge sys_clk);
		mgmt_rd = 1'b0;
		rdata = mgmt_rdata_q;
		rdata1 = one_rdata;
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge sys_clk);
		mgmt_addr = a;
		mgmt_wdata = d;
		mgmt_wr = 1'b1;
		@(negedge sys_clk);
		mgmt_wr = 1'b0;
	endtask

	task automatic chk_rd(input string nm, input logic [4:0] a, input logic [15:0] e);
		rd(a);
		`CHK(nm, e, rdata)
	endtask

	// Straps must be stable before release since capture happens on the first edge
	task automatic do_reset(input logic hi, input logic lo, input logic x);
		@(negedge sys_clk);
		rst_b = 1'b0;
		p_en = 1'b0;
		advert_strap_hi = hi;
		advert_strap_lo = lo;
		crossover_strap_enable = x;
		repeat (2) @(negedge sys_clk);
		rst_b = 1'b1;
	endtask

	task automatic wait_mv();
		for (int i = 0; i < 2000 && mode_valid_q !== 1'b1; i++) @(negedge sys_clk);
		`CHK("mode_valid", 1'b1, mode_valid_q)
	endtask

	task automatic end_of_test();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge sys_clk);
		n_fail++;
		end_of_test();
	end

	initial begin
		for (int k = 0; k < 4; k++) begin
			do_reset(k[1], k[0], 1'b1);
			chk_rd("advert", `AAC_ADDR_ADVERT, adv(stab[k]));
			`CHK("advert one strap", adv(k[0] ? 4'b1111 : 4'b0101), rdata1)
		end
		chk_rd("basic_ctrl", `AAC_ADDR_BASIC_CTRL, 16'h3100);
		advert_strap_hi = 1'b0;
		advert_strap_lo = 1'b0;
		chk_rd("advert held", `AAC_ADDR_ADVERT, adv(4'b1111));
		wr(`AAC_ADDR_ADVERT, 16'h0000);
		chk_rd("advert wr0", `AAC_ADDR_ADVERT, 16'h0001);
		wr(`AAC_ADDR_ADVERT, 16'hFFFF);
		chk_rd("advert wr1", `AAC_ADDR_ADVERT, 16'h01E1);
		chk_rd("unmapped", 5'h1F, 16'h0000);
		// Crossover: strap high toggles swap on the first slot, strap low never swaps
		do_reset(1'b1, 1'b1, 1'b1);
		repeat (60) @(negedge sys_clk);
		`CHK("swap on", 1'b1, mdix_swap_q)
		do_reset(1'b1, 1'b1, 1'b0);
		seen = 1'b0;
		repeat (200) @(negedge sys_clk) seen |= mdix_swap_q;
		`CHK("swap off", 1'b0, seen)
		for (int k = 0; k < 4; k++) begin
			do_reset(1'b1, 1'b1, 1'b1);
			p_abil = ptab[k];
			p_en = 1'b1;
			wait_mv();
			`CHK("speed", ptab[k] > 4'b0011, speed_100_q)
			`CHK("duplex", k % 2 == 0, full_duplex_q)
		end
		// Losing the link falls back to negotiation, and a returning partner relinks
		p_en = 1'b0;
		repeat (3) @(negedge sys_clk);
		`CHK("link lost", 1'b0, mode_valid_q)
		p_en = 1'b1;
		wait_mv();
		do_reset(1'b0, 1'b0, 1'b1);
		p_abil = 4'b1100;
		p_en = 1'b1;
		repeat (300) @(negedge sys_clk);
		`CHK("no common", 1'b0, mode_valid_q)
		`CHK("pulses", 1'b1, n_flp > 0)
		wr(`AAC_ADDR_BASIC_CTRL, 16'h1200);
		n0 = n_flp;
		repeat (15) @(negedge sys_clk);
		`CHK("break quiet", n0, n_flp)
		repeat (40) @(negedge sys_clk);
		`CHK("pulses again", 1'b1, n_flp > n0)
		wr(`AAC_ADDR_BASIC_CTRL, 16'h2100);
		repeat (3) @(negedge sys_clk);
		`CHK("forced speed", 1'b1, speed_100_q)
		`CHK("forced duplex", 1'b1, full_duplex_q)
		`CHK("forced valid", 1'b1, mode_valid_q)
		wr(`AAC_ADDR_BASIC_CTRL, 16'h0000);
		repeat (3) @(negedge sys_clk);
		`CHK("forced 10", 1'b0, speed_100_q)
		`CHK("forced half", 1'b0, full_duplex_q)
		chk_rd("basic_ctrl wr", `AAC_ADDR_BASIC_CTRL, 16'h0000);
		// Turning negotiation back on leaves forced mode through the break time
		wr(`AAC_ADDR_BASIC_CTRL, 16'h1000);
		repeat (3) @(negedge sys_clk);
		`CHK("enable restarts", 1'b0, mode_valid_q)
		wr(`AAC_ADDR_BASIC_CTRL, 16'h8000);
		chk_rd("soft reset", `AAC_ADDR_BASIC_CTRL, 16'h3100);
		end_of_test();
	end
endmodule
